// ### icu_consts.svh
// Purpose: constants of the input conditioning unit
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: included by icu_pkg.sv and icu_top.sv
`ifndef ICU_CONSTS_SVH
`define ICU_CONSTS_SVH
`define ICU_NUM_IN 32
`define ICU_NUM_SOFT 4
`define ICU_NUM_VOUT 6
`define ICU_CLK_HZ 40000000
`define ICU_TICK_US 10
`define ICU_TICK_CYC ((`ICU_CLK_HZ / 1000000) * `ICU_TICK_US)
`define ICU_DLY_MAX_10MS 6000
`define ICU_TICKS_PER_10MS 1000
`define ICU_CNT_MAX 16'hFFFF
`define ICU_A_STATUS 12'h000
`define ICU_A_INVERT 12'h004
`define ICU_A_ALARM_EN 12'h008
`define ICU_A_ON_EV_EN 12'h00C
`define ICU_A_OFF_EV_EN 12'h010
`define ICU_A_ALARM 12'h014
`define ICU_A_EVENT 12'h018
`define ICU_A_SOFT 12'h01C
`define ICU_A_VOUT 12'h020
`define ICU_A_SEL 12'h024
`define ICU_A_DELAY 12'h028
`define ICU_A_COUNT 12'h02C
`define ICU_A_SOFT_EV 12'h030
`define ICU_A_RAW 12'h034
`define ICU_F_SOFT_EV_EN 4
`endif

// ### icu_pkg.sv
// Purpose: types of the input conditioning unit
// Assumes: icu_consts.svh
// Notes: none
`include "icu_consts.svh"
package icu_pkg;
  typedef logic [`ICU_NUM_IN-1:0] icu_in_vec_t;
  typedef logic [`ICU_NUM_SOFT-1:0] icu_soft_vec_t;
  typedef logic [`ICU_NUM_VOUT-1:0] icu_vout_vec_t;
  typedef logic [15:0] icu_cnt_t;
  typedef logic [12:0] icu_dly_t;
  typedef enum logic [1:0] {
    ICU_BUS_IDLE = 2'h1,
    ICU_BUS_ACK = 2'h2
  } icu_bus_st_t;
endpackage : icu_pkg

// ### icu_top.sv
// Purpose: binary input conditioning with soft inputs and soft outputs
// Assumes: one 40 MHz clock, classic wishbone slave, 32-bit data
// Notes: delays in 10 ms steps, all inputs share one 10 us tick
// Behaviour
// RULE_01: up to thirty-two binary inputs each give a 0/1 status bit.
// RULE_02: the invert bit of an input makes its active edge 1-to-0 instead of 0-to-1.
// RULE_03: one delay of 0 to 60.00 s applies to both directions before the conditioned state changes.
// RULE_04: each input counts active edges from 0 to 65535 and software may preset the count.
// RULE_05: an active edge raises an alarm popup request only when the alarm option is on.
// RULE_06: an active edge makes an event only when the on-event enable is on.
// RULE_07: an inactive edge makes an event only when the off-event enable is on.
// RULE_08: conditioned inputs are driven out to the output matrix, block matrix and logic.
// RULE_09: four soft inputs act like binary inputs toward every consumer.
// RULE_10: soft input states are written by software and an event follows a change only if enabled.
// RULE_11: soft inputs are available as the setting group selector.
// RULE_12: six soft outputs act as relays without contacts.
// RULE_13: soft outputs are driven to the output matrix and the block matrix.
// RULE_14: soft outputs are driven to the programmable logic and the group switch.
// RULE_15: raw inputs pass two flip-flops and a level change during the delay restarts its timer.
// RULE_16: an active edge at count 65535 wraps the count to zero.
`timescale 1ns/1ps
`default_nettype none
`include "icu_consts.svh"
module icu_top #(
  parameter int NUM_IN = `ICU_NUM_IN,
  parameter int TICK_CYC = `ICU_TICK_CYC
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // field inputs
  input wire icu_pkg::icu_in_vec_t binary_input_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [11:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // conditioned signals
  output icu_pkg::icu_in_vec_t binary_input_out,
  output icu_pkg::icu_soft_vec_t soft_input_out,
  output icu_pkg::icu_vout_vec_t soft_output_out,
  output icu_pkg::icu_in_vec_t alarm_req_out,
  output icu_pkg::icu_in_vec_t event_on_out,
  output icu_pkg::icu_in_vec_t event_off_out,
  output icu_pkg::icu_soft_vec_t soft_event_out
);
  import icu_pkg::*;

  icu_in_vec_t sync1_r, sync2_r, last_raw_r;
  icu_in_vec_t cond_r, cond_nxt, invert_r, invert_nxt, alarm_en_r, alarm_en_nxt;
  icu_in_vec_t on_en_r, on_en_nxt, off_en_r, off_en_nxt;
  icu_in_vec_t alarm_r, alarm_nxt, ev_on_r, ev_on_nxt, ev_off_r, ev_off_nxt;
  icu_in_vec_t act_edge, inact_edge, edge_any;
  icu_soft_vec_t soft_r, soft_nxt, soft_ev_r, soft_ev_nxt, soft_ev_en_r, soft_ev_en_nxt;
  icu_vout_vec_t vout_r, vout_nxt;
  icu_cnt_t cnt_r [NUM_IN];
  icu_cnt_t cnt_nxt [NUM_IN];
  icu_dly_t dly_r [NUM_IN];
  icu_dly_t dly_nxt [NUM_IN];
  logic [22:0] tmr_r [NUM_IN];
  logic [22:0] tmr_nxt [NUM_IN];
  logic [4:0] sel_r, sel_nxt;
  logic [15:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  icu_bus_st_t st_r, st_nxt;
  logic [31:0] rdat_nxt;
  logic ack_nxt;
  logic wr, acc;

  // two flops before any logic looks at the field level
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= binary_input_in; // RULE_15
      sync2_r <= sync1_r; // RULE_15
    end
  end

  // shared time base; one tick per 10 us keeps per-input timers small
  always_comb
  begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 16'h0001;
    if (tick_cnt_r == 16'(TICK_CYC - 1))
    begin
      tick_cnt_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  assign acc = wb_cyc_in && wb_stb_in && (st_r == ICU_BUS_IDLE);
  assign wr = acc && wb_we_in && wb_sel_in[0];

  // per-input delay and edge detection
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++)
    begin : g_in
      always_comb
      begin
        tmr_nxt[g] = tmr_r[g];
        cond_nxt[g] = cond_r[g];
        if (sync2_r[g] != last_raw_r[g] || sync2_r[g] == cond_r[g])
          tmr_nxt[g] = '0; // RULE_15
        else if (tmr_r[g] >= 23'(dly_r[g]) * 23'(`ICU_TICKS_PER_10MS))
        begin
          cond_nxt[g] = sync2_r[g]; // RULE_03
          tmr_nxt[g] = '0;
        end
        else if (tick_r)
          tmr_nxt[g] = tmr_r[g] + 23'h000001;
      end
      // active level follows polarity, so edges are judged after inversion
      assign act_edge[g] = (cond_nxt[g] != cond_r[g]) && (cond_nxt[g] ^ invert_r[g]); // RULE_02
      assign inact_edge[g] = (cond_nxt[g] != cond_r[g]) && !(cond_nxt[g] ^ invert_r[g]); // RULE_02
      assign edge_any[g] = act_edge[g];
      always_comb
      begin
        cnt_nxt[g] = cnt_r[g];
        dly_nxt[g] = dly_r[g];
        if (wr && wb_adr_in == `ICU_A_DELAY && sel_r == 5'(g))
          dly_nxt[g] = (wb_dat_in[12:0] > 13'(`ICU_DLY_MAX_10MS)) ? 13'(`ICU_DLY_MAX_10MS) : wb_dat_in[12:0]; // RULE_03
        // an edge in the same cycle as a preset is counted on top of it
        if (wr && wb_adr_in == `ICU_A_COUNT && sel_r == 5'(g))
          cnt_nxt[g] = wb_dat_in[15:0] + {15'h0000, act_edge[g]}; // RULE_04
        else if (act_edge[g])
          cnt_nxt[g] = (cnt_r[g] == `ICU_CNT_MAX) ? 16'h0000 : cnt_r[g] + 16'h0001; // RULE_16
      end
      always_ff @(posedge clk_sys_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          tmr_r[g] <= '0;
          cnt_r[g] <= '0;
          dly_r[g] <= '0;
        end
        else
        begin
          tmr_r[g] <= tmr_nxt[g];
          cnt_r[g] <= cnt_nxt[g];
          dly_r[g] <= dly_nxt[g];
        end
      end
    end
  endgenerate

  // lanes above NUM_IN are not fitted: their conditioned state is held at 0 and they never make an edge
  genvar u;
  generate
    for (u = NUM_IN; u < `ICU_NUM_IN; u++)
    begin : g_absent
      always_comb
      begin
        cond_nxt[u] = 1'b0; // RULE_01
      end
      assign act_edge[u] = 1'b0;
      assign inact_edge[u] = 1'b0;
      assign edge_any[u] = 1'b0;
    end
  endgenerate

  // configuration, sticky flags and bus answer
  always_comb
  begin
    invert_nxt = invert_r;
    alarm_en_nxt = alarm_en_r;
    on_en_nxt = on_en_r;
    off_en_nxt = off_en_r;
    soft_nxt = soft_r;
    soft_ev_en_nxt = soft_ev_en_r;
    vout_nxt = vout_r;
    sel_nxt = sel_r;
    alarm_nxt = alarm_r;
    ev_on_nxt = ev_on_r;
    ev_off_nxt = ev_off_r;
    soft_ev_nxt = soft_ev_r;
    rdat_nxt = 32'h00000000;
    ack_nxt = 1'b0;
    st_nxt = ICU_BUS_IDLE;
    if (acc)
    begin
      ack_nxt = 1'b1;
      st_nxt = ICU_BUS_ACK;
      case (wb_adr_in)
        `ICU_A_STATUS: rdat_nxt = cond_r ^ invert_r; // RULE_01
        `ICU_A_INVERT: rdat_nxt = invert_r;
        `ICU_A_ALARM_EN: rdat_nxt = alarm_en_r;
        `ICU_A_ON_EV_EN: rdat_nxt = on_en_r;
        `ICU_A_OFF_EV_EN: rdat_nxt = off_en_r;
        `ICU_A_ALARM: rdat_nxt = alarm_r;
        `ICU_A_EVENT: rdat_nxt = ev_on_r;
        `ICU_A_SOFT: rdat_nxt = {24'h000000, soft_ev_r, soft_r};
        `ICU_A_VOUT: rdat_nxt = {26'h0000000, vout_r};
        `ICU_A_SEL: rdat_nxt = {27'h0000000, sel_r};
        `ICU_A_DELAY: rdat_nxt = {19'h00000, dly_r[sel_r]};
        `ICU_A_COUNT: rdat_nxt = {16'h0000, cnt_r[sel_r]}; // RULE_04
        `ICU_A_SOFT_EV: rdat_nxt = {24'h000000, soft_ev_en_r, soft_ev_r};
        `ICU_A_RAW: rdat_nxt = ev_off_r;
        default: rdat_nxt = 32'h00000000;
      endcase
      if (wr)
      begin
        case (wb_adr_in)
          `ICU_A_INVERT: invert_nxt = wb_dat_in;
          `ICU_A_ALARM_EN: alarm_en_nxt = wb_dat_in;
          `ICU_A_ON_EV_EN: on_en_nxt = wb_dat_in;
          `ICU_A_OFF_EV_EN: off_en_nxt = wb_dat_in;
          `ICU_A_ALARM: alarm_nxt = alarm_r & ~wb_dat_in;
          `ICU_A_EVENT: ev_on_nxt = ev_on_r & ~wb_dat_in;
          `ICU_A_RAW: ev_off_nxt = ev_off_r & ~wb_dat_in;
          `ICU_A_SOFT: soft_nxt = wb_dat_in[`ICU_NUM_SOFT-1:0]; // RULE_10
          `ICU_A_VOUT: vout_nxt = wb_dat_in[`ICU_NUM_VOUT-1:0]; // RULE_12
          `ICU_A_SEL: sel_nxt = wb_dat_in[4:0];
          `ICU_A_SOFT_EV: soft_ev_nxt = soft_ev_r & ~wb_dat_in[`ICU_NUM_SOFT-1:0];
          `ICU_A_COUNT, `ICU_A_DELAY: ;
          default: ;
        endcase
        if (wb_adr_in == `ICU_A_SOFT_EV)
          soft_ev_en_nxt = wb_dat_in[`ICU_F_SOFT_EV_EN +: `ICU_NUM_SOFT];
      end
    end
    // hardware set beats a software clear in the same cycle
    alarm_nxt = alarm_nxt | (edge_any & alarm_en_r); // RULE_05
    ev_on_nxt = ev_on_nxt | (act_edge & on_en_r); // RULE_06
    ev_off_nxt = ev_off_nxt | (inact_edge & off_en_r); // RULE_07
    soft_ev_nxt = soft_ev_nxt | ((soft_nxt ^ soft_r) & soft_ev_en_r); // RULE_10
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      last_raw_r <= '0;
      cond_r <= '0;
      invert_r <= '0;
      alarm_en_r <= '0;
      on_en_r <= '0;
      off_en_r <= '0;
      alarm_r <= '0;
      ev_on_r <= '0;
      ev_off_r <= '0;
      soft_r <= '0;
      soft_ev_r <= '0;
      soft_ev_en_r <= '0;
      vout_r <= '0;
      sel_r <= '0;
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      st_r <= ICU_BUS_IDLE;
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
      binary_input_out <= '0;
      soft_input_out <= '0;
      soft_output_out <= '0;
      alarm_req_out <= '0;
      event_on_out <= '0;
      event_off_out <= '0;
      soft_event_out <= '0;
    end
    else
    begin
      last_raw_r <= sync2_r;
      cond_r <= cond_nxt;
      invert_r <= invert_nxt;
      alarm_en_r <= alarm_en_nxt;
      on_en_r <= on_en_nxt;
      off_en_r <= off_en_nxt;
      alarm_r <= alarm_nxt;
      ev_on_r <= ev_on_nxt;
      ev_off_r <= ev_off_nxt;
      soft_r <= soft_nxt;
      soft_ev_r <= soft_ev_nxt;
      soft_ev_en_r <= soft_ev_en_nxt;
      vout_r <= vout_nxt;
      sel_r <= sel_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      st_r <= st_nxt;
      wb_ack_out <= ack_nxt;
      wb_dat_out <= rdat_nxt;
      binary_input_out <= cond_nxt ^ invert_nxt; // RULE_08
      soft_input_out <= soft_nxt; // RULE_09 RULE_11
      soft_output_out <= vout_nxt; // RULE_13 RULE_14
      alarm_req_out <= alarm_nxt; // RULE_05
      event_on_out <= ev_on_nxt;
      event_off_out <= ev_off_nxt;
      soft_event_out <= soft_ev_nxt;
    end
  end
endmodule : icu_top
`default_nettype wire

// ### icu_asserts.sv
// Purpose: bus and flag relations of icu_top
// Assumes: bound into icu_top, one clock domain
// Notes: flags are checked for clearing only, set timing is left to the bench
`timescale 1ns/1ps
`default_nettype none
`include "icu_consts.svh"
module icu_asserts (
  // clock, reset and bus
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [11:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // flags and soft signals
  input wire icu_pkg::icu_in_vec_t alarm_req_out,
  input wire icu_pkg::icu_in_vec_t event_on_out,
  input wire icu_pkg::icu_in_vec_t event_off_out,
  input wire icu_pkg::icu_soft_vec_t soft_input_out,
  input wire icu_pkg::icu_vout_vec_t soft_output_out
);
  import icu_pkg::*;
  logic wr_en;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // sel[0] gates every write, so a write without it must leave state alone
  assign wr_en = wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0];
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  a_req_acked: assert property (s_req |=> wb_ack_out) else $error("request not answered next cycle");
  a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack without request");
  a_idle_dat: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data outside ack");
  a_alarm_clear: assert property (|($past(alarm_req_out) & ~alarm_req_out) |->
    $past(wr_en && wb_adr_in == `ICU_A_ALARM)) else $error("alarm flag lost without clear");
  a_on_clear: assert property (|($past(event_on_out) & ~event_on_out) |->
    $past(wr_en && wb_adr_in == `ICU_A_EVENT)) else $error("on event lost without clear");
  a_off_clear: assert property (|($past(event_off_out) & ~event_off_out) |->
    $past(wr_en && wb_adr_in == `ICU_A_RAW)) else $error("off event lost without clear");
  a_soft_write: assert property ($changed(soft_input_out) |->
    $past(wr_en && wb_adr_in == `ICU_A_SOFT) && soft_input_out == $past(wb_dat_in[3:0]))
    else $error("soft input changed without write");
  a_vout_write: assert property ($changed(soft_output_out) |->
    $past(wr_en && wb_adr_in == `ICU_A_VOUT) && soft_output_out == $past(wb_dat_in[5:0]))
    else $error("soft output changed without write");
endmodule : icu_asserts
`default_nettype wire

// ### icu_field.sv
// Purpose: field contact model feeding the binary inputs
// Assumes: contacts follow the bench command one clock later
// Notes: no bounce modelled, the bench forces delay restarts itself
`timescale 1ns/1ps
`default_nettype none
module icu_field (
  // clock
  input wire logic clk_sys_in,
  // contact command and contact level
  input wire logic [31:0] close_in,
  output icu_pkg::icu_in_vec_t level_out
);
  import icu_pkg::*;
  always_ff @(posedge clk_sys_in)
  begin
    level_out <= close_in;
  end
endmodule : icu_field
`default_nettype wire

// ### tb.sv
// Purpose: directed bench for icu_top
// Assumes: tick of one cycle, so a 10 ms step is 1000 cycles
// Notes: outputs are read on the falling edge, clear of update races, except rd data and the no alarm check at the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "icu_consts.svh"
module tb;
  import icu_pkg::*;
  logic clk_sys_in, rstn_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [11:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, cmd, q;
  icu_in_vec_t bi, bo, alr, evn, evf;
  icu_soft_vec_t sio, sev;
  icu_vout_vec_t soo;
  int fail_count = 0;
  int n_checks = 0;
  icu_field u_field (.clk_sys_in, .close_in(cmd), .level_out(bi));
  icu_top #(.TICK_CYC(1)) u_dut (.clk_sys_in, .rstn_in, .binary_input_in(bi), .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .binary_input_out(bo),
    .soft_input_out(sio), .soft_output_out(soo), .alarm_req_out(alr), .event_on_out(evn),
    .event_off_out(evf), .soft_event_out(sev));
  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    wb_sel_in <= s;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (wb_ack_out !== 1'b1 && n < 50);
    if (wb_ack_out !== 1'b1)
    begin
      fail_count++;
      $display("Error ack expected 1 seen %b", wb_ack_out);
    end
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'hF);
    check(nm, q, exp);
  endtask : rd
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask : step
  task automatic field(input logic [31:0] v);
    @(posedge clk_sys_in);
    cmd <= v;
  endtask : field
  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // about 2900 cycles are needed, the margin covers slow answers
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    {rstn_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_sel_in, wb_dat_in, cmd} = '0;
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (int a = 0; a <= 'h40; a += 4)
      rd("reset", a[11:0], 32'h0);
    wr(`ICU_A_ALARM_EN, 32'h1);
    wr(`ICU_A_ON_EV_EN, 32'h1);
    wr(`ICU_A_OFF_EV_EN, 32'h1);
    field(32'h3);
    step(8);
    check("status", bo, 32'h3);
    check("alarm", alr, 32'h1);
    check("on ev", evn, 32'h1);
    check("off ev", evf, 32'h0);
    field(32'h0);
    step(8);
    check("off ev", evf, 32'h1);
    wr(`ICU_A_SEL, 32'h0);
    rd("count", `ICU_A_COUNT, 32'h1);
    xfer(1'b1, `ICU_A_ALARM, 32'h1, 4'h0);
    step(1);
    check("sel0", alr, 32'h1);
    wr(`ICU_A_ALARM, 32'h1);
    wr(`ICU_A_EVENT, 32'h1);
    wr(`ICU_A_RAW, 32'h1);
    step(1);
    check("clear", alr | evn | evf, 32'h0);
    wr(`ICU_A_INVERT, 32'h4);
    step(2);
    check("invert", bo, 32'h4);
    field(32'h4);
    step(8);
    check("invert hi", bo, 32'h0);
    wr(`ICU_A_SEL, 32'h3);
    wr(`ICU_A_COUNT, 32'hFFFF);
    rd("preset", `ICU_A_COUNT, 32'hFFFF);
    field(32'hC);
    step(8);
    rd("wrap", `ICU_A_COUNT, 32'h0);
    check("no alarm", alr, 32'h0);
    rd("status rd", `ICU_A_STATUS, 32'h8);
    wr(`ICU_A_SEL, 32'h4);
    wr(`ICU_A_DELAY, 32'h1);
    field(32'h1C);
    step(500);
    field(32'hC);
    step(3);
    field(32'h1C);
    step(900);
    check("restart", bo[4], 1'b0);
    step(200);
    check("delay on", bo[4], 1'b1);
    field(32'hC);
    step(900);
    check("hold on", bo[4], 1'b1);
    step(200);
    check("delay off", bo[4], 1'b0);
    wr(`ICU_A_DELAY, 32'h1FFF);
    rd("clamp", `ICU_A_DELAY, 32'h1770);
    wr(`ICU_A_SOFT_EV, 32'h10);
    wr(`ICU_A_SOFT, 32'h3);
    step(2);
    check("soft in", sio, 4'h3);
    check("soft ev", sev, 4'h1);
    rd("soft rd", `ICU_A_SOFT, 32'h13);
    wr(`ICU_A_SOFT_EV, 32'h11);
    step(2);
    check("soft clr", sev, 4'h0);
    rd("soft ev rd", `ICU_A_SOFT_EV, 32'h10);
    wr(`ICU_A_VOUT, 32'h3F);
    rd("vout", `ICU_A_VOUT, 32'h3F);
    wr(12'h040, 32'h0);
    wr(`ICU_A_VOUT, 32'h15);
    step(1);
    check("vout out", soo, 6'h15);
    end_of_test();
  end
endmodule : tb
bind icu_top icu_asserts u_chk (.clk_sys_in, .rstn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
  .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .alarm_req_out, .event_on_out, .event_off_out,
  .soft_input_out, .soft_output_out);
`default_nettype wire
